//--- link_pkg.sv
package link_pkg;

    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int BIT_W = 10;
    localparam int CNT_W = 16;

    // Clock is 250 MHz
    localparam int CLK_PERIOD_NS = 4;

    // Calibration character holds the line low for this many bit times
    localparam int CAL_LOW_BITS = 8;
    localparam int CAL_SHIFT = 3;
    localparam logic [7:0] CAL_CHAR = 8'h80;

    // Slowest rate is sys_clk / 576 (LOW_MAX / 8), fastest accepted sys_clk / 4
    localparam logic [BIT_W-1:0] BIT_MAX = 10'h200;
    localparam logic [CNT_W-1:0] CAL_MIN = 16'h0020;

    // Break: nine low bit times received, forty (four characters) sent back
    localparam int BREAK_BITS = 9;
    localparam int BRK_TX_BITS = 40;
    localparam logic [CNT_W-1:0] LOW_MAX = 16'h1200;
    localparam logic [CNT_W-1:0] BRK_UNCAL_LEN = 16'h5000;

    // Bit indices of a character: start, eight data, stop
    localparam logic [3:0] IDX_START = 4'h0;
    localparam logic [3:0] IDX_LAST_DATA = 4'h8;
    localparam logic [3:0] IDX_STOP = 4'h9;

    localparam logic [1:0] STRAP_SAMPLE = 2'h2;
    localparam logic [1:0] STRAP_DONE = 2'h3;

    typedef enum logic [7:0] {
        S_CAL_WAIT = 8'h01,
        S_CAL_MEAS = 8'h02,
        S_IDLE = 8'h04,
        S_RX = 8'h08,
        S_RX_PUSH = 8'h10,
        S_TX = 8'h20,
        S_BRK_TX = 8'h40,
        S_BRK_WAIT = 8'h80
    } link_state_t;

endpackage

//--- bit_sync.sv
module bit_sync
#(
    parameter logic RST_VAL = 1'h1
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);

    typedef struct packed {
        logic s1;
        logic s2;
    } sync_t;

    sync_t q;
    sync_t d;

    always_comb
    begin
        d.s1 = din;
        d.s2 = q.s1;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            q <= {RST_VAL, RST_VAL};
        end
        else
        begin
            q <= d;
        end
    end

    assign dout = q.s2;

endmodule // bit_sync

//--- byte_fifo.sv
module byte_fifo
    import link_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] count;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic in_rdy;
        logic out_vld;
    } fifo_t;

    fifo_t q;
    fifo_t d;
    logic push;
    logic pop;

    always_comb
    begin
        d = q;
        push = in_valid && q.in_rdy;
        pop = out_ready && q.out_vld;
        if (push)
        begin
            d.mem[q.wp] = in_data;
            d.wp = q.wp + 1'h1;
        end
        if (pop)
        begin
            d.rp = q.rp + 1'h1;
        end
        if (push && !pop)
        begin
            d.count = q.count + 1'h1;
        end
        else if (pop && !push)
        begin
            d.count = q.count - 1'h1;
        end
        // Flags are registered so both handshakes come straight from flops
        d.in_rdy = (d.count != FULL_CNT);
        d.out_vld = (d.count != '0);
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
            q.in_rdy <= 1'h1;
        end
        else
        begin
            q <= d;
        end
    end

    assign in_ready = q.in_rdy;
    assign out_valid = q.out_vld;
    assign out_data = q.mem[q.rp];

endmodule // byte_fifo

//--- debug_link_top.sv
// What this block does
// R1 - One open-drain pin, half-duplex, both directions
// R2 - Start low, eight bits LSB first, 1.5 stop
// R3 - Idle after reset until 80H calibrates
// R4 - Bit time from eight low bits of 80H
// R5 - Baud logic on sys_clk, down to clk/512
// R6 - Host keeps rate at or below clk/8
// R7 - Nine low bit times reset the baud logic
// R8 - Debug mode halts fetch except directed instructions
// R9 - Clock and peripherals run unless stop mode
// R10 - Entering debug mode leaves halt mode
// R11 - Debug mode refreshes enabled watchdog continuously
// R12 - Host writing mode bit one enters debug
// R13 - Enabled breakpoint instruction enters debug mode
// R14 - Watchpoint match enters debug mode
// R15 - Pin low at reset exit enters debug
// R16 - Clearing mode bit leaves debug mode
// R17 - Power-on, brownout, reset pin leave debug
// R18 - Pin low in stop mode starts reset
// R19 - Flag low stop bit and transmit collision
// R20 - Errors abort, send four-character break, recalibrate
// R21 - Host break keeps control register and mode
// R22 - Link held reset until pin returns high
// R23 - Sample data bits mid bit period
// R24 - Release pin for high, never drive high
// R25 - Low pin while releasing means collision
module debug_link_top
    import link_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic debug_pin_i,
    output logic debug_pin_o,
    output logic debug_pin_oe_n,
    output logic [DATA_W-1:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic [DATA_W-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic link_abort,
    output logic frame_err,
    output logic tx_collision,
    input wire logic ctl_write,
    input wire logic ctl_mode_bit,
    input wire logic bp_hit,
    input wire logic bp_enable,
    input wire logic wp_match,
    input wire logic exec_req,
    input wire logic halt_mode,
    input wire logic stop_mode,
    input wire logic wdt_enable,
    input wire logic por_reset,
    input wire logic brownout_reset,
    input wire logic reset_pin_n,
    output logic debug_mode,
    output logic fetch_halt,
    output logic halt_exit,
    output logic wdt_refresh,
    output logic periph_run,
    output logic sys_reset_req
);

    typedef struct packed {
        link_state_t st;
        logic cal;
        logic [BIT_W-1:0] bit_t;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] low_run;
        logic [3:0] idx;
        logic [9:0] sh;
        logic oe_n;
        logic pin_o;
        logic push;
        logic [DATA_W-1:0] push_data;
        logic tx_rdy;
        logic abort;
        logic frame_err;
        logic collide;
        logic mode;
        logic [1:0] strap_cnt;
        logic fetch_halt;
        logic halt_exit;
        logic wdt_ref;
        logic run;
        logic sys_rst;
    } core_t;

    core_t q;
    core_t d;
    logic pin_s;
    logic reset_pin_s;
    logic fifo_in_ready;
    logic listening;
    logic go_break;
    logic go_err;
    logic dev_rst;
    logic mode_set;
    logic mode_clr;
    logic [CNT_W-1:0] brk_lim;
    logic [CNT_W-1:0] brk_len;
    logic [CNT_W-1:0] bit_cnt;
    logic [CNT_W-1:0] half_cnt;

    bit_sync #(.RST_VAL(1'h1)) u_pin_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .din(debug_pin_i),
        .dout(pin_s)
    );

    bit_sync #(.RST_VAL(1'h1)) u_rstpin_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .din(reset_pin_n),
        .dout(reset_pin_s)
    );

    // Received bytes wait here for the command decoder; a full buffer holds the receiver
    byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_data(q.push_data),
        .in_valid(q.push),
        .in_ready(fifo_in_ready),
        .out_data(rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

    always_comb
    begin
        d = q;
        d.abort = 1'h0;
        d.frame_err = 1'h0;
        d.collide = 1'h0;
        d.halt_exit = 1'h0;
        d.pin_o = 1'h0;
        go_err = 1'h0;
        bit_cnt = {6'h00, q.bit_t} - 16'h0001;
        half_cnt = {7'h00, q.bit_t[BIT_W-1:1]};
        brk_lim = q.cal ? ({3'h0, q.bit_t, 3'h0} + {6'h00, q.bit_t}) : LOW_MAX; // [R7]
        brk_len = q.cal ? ({1'h0, q.bit_t, 5'h00} + {3'h0, q.bit_t, 3'h0}) : BRK_UNCAL_LEN;
        listening = (q.st == S_CAL_WAIT) || (q.st == S_CAL_MEAS) || (q.st == S_IDLE)
            || (q.st == S_RX) || (q.st == S_RX_PUSH);
        d.low_run = (listening && !pin_s) ? q.low_run + 16'h0001 : 16'h0000;
        go_break = listening && !pin_s && (q.low_run >= brk_lim); // [R7]

        case (q.st)
            S_CAL_WAIT:
            begin
                if (!pin_s) // [R3]
                begin
                    d.st = S_CAL_MEAS;
                end
            end
            S_CAL_MEAS:
            begin
                if (pin_s)
                begin
                    if (q.low_run < CAL_MIN)
                    begin
                        d.st = S_CAL_WAIT;
                    end
                    else
                    begin
                        // Low run covers start plus seven zero bits of 80H
                        d.bit_t = q.low_run[CAL_SHIFT+BIT_W-1:CAL_SHIFT]; // [R4] [R5]
                        d.cal = 1'h1;
                        d.st = S_IDLE;
                    end
                end
            end
            S_IDLE:
            begin
                if (tx_valid && q.tx_rdy)
                begin
                    d.sh = {1'h1, tx_data, 1'h0}; // [R2]
                    d.idx = IDX_START;
                    d.cnt = bit_cnt;
                    d.oe_n = 1'h0;
                    d.st = S_TX;
                end
                else if (!pin_s)
                begin
                    d.cnt = half_cnt; // [R23]
                    d.idx = IDX_START;
                    d.st = S_RX;
                end
            end
            S_RX:
            begin
                if (q.cnt != '0)
                begin
                    d.cnt = q.cnt - 16'h0001;
                end
                else if (q.idx == IDX_START)
                begin
                    if (pin_s)
                    begin
                        d.st = S_IDLE;
                    end
                    else
                    begin
                        d.cnt = bit_cnt;
                        d.idx = q.idx + 4'h1;
                    end
                end
                else if (q.idx <= IDX_LAST_DATA)
                begin
                    d.sh = {q.sh[9:8], pin_s, q.sh[7:1]}; // [R2] [R23]
                    d.cnt = bit_cnt;
                    d.idx = q.idx + 4'h1;
                end
                else if (!pin_s)
                begin
                    d.frame_err = 1'h1; // [R19]
                    go_err = 1'h1;
                end
                else
                begin
                    d.push = 1'h1;
                    d.push_data = q.sh[7:0];
                    d.st = S_RX_PUSH;
                end
            end
            S_RX_PUSH:
            begin
                if (fifo_in_ready)
                begin
                    d.push = 1'h0;
                    d.st = S_IDLE;
                end
            end
            S_TX:
            begin
                // Pin sync lags two cycles, so the check waits for mid bit
                if (q.oe_n && !pin_s && (q.cnt == half_cnt))
                begin
                    d.collide = 1'h1; // [R19] [R25]
                    go_err = 1'h1;
                end
                if (q.cnt != '0)
                begin
                    d.cnt = q.cnt - 16'h0001;
                end
                else if (q.idx == IDX_STOP)
                begin
                    d.oe_n = 1'h1;
                    d.st = S_IDLE;
                end
                else
                begin
                    d.sh = {1'h1, q.sh[9:1]};
                    d.idx = q.idx + 4'h1;
                    d.oe_n = q.sh[1]; // [R24]
                    d.cnt = (q.idx == IDX_LAST_DATA) ? bit_cnt + half_cnt : bit_cnt; // [R2]
                end
            end
            S_BRK_TX:
            begin
                if (q.cnt != '0)
                begin
                    d.cnt = q.cnt - 16'h0001;
                end
                else
                begin
                    d.oe_n = 1'h1;
                    d.st = S_BRK_WAIT;
                end
            end
            S_BRK_WAIT:
            begin
                // Link stays in reset for as long as anyone holds the line low
                if (pin_s) // [R22]
                begin
                    d.cal = 1'h0; // [R7] [R20]
                    d.st = S_CAL_WAIT;
                end
            end
            default:
            begin
                d.st = S_CAL_WAIT;
            end
        endcase

        if (go_break || go_err)
        begin
            d.abort = 1'h1; // [R20]
            d.push = 1'h0;
            d.cnt = brk_len - 16'h0001;
            d.oe_n = 1'h0;
            d.st = S_BRK_TX;
        end
        d.tx_rdy = (d.st == S_IDLE) && d.cal && !q.push; // [R1]

        // Mode control is untouched by link breaks and errors
        dev_rst = por_reset || brownout_reset || !reset_pin_s;
        mode_set = (ctl_write && ctl_mode_bit) || (bp_hit && bp_enable) || wp_match
            || ((q.strap_cnt == STRAP_SAMPLE) && !pin_s);
        mode_clr = ctl_write && !ctl_mode_bit;
        if (dev_rst)
        begin
            d.mode = 1'h0; // [R17]
            d.strap_cnt = 2'h0;
        end
        else
        begin
            if (q.strap_cnt != STRAP_DONE)
            begin
                d.strap_cnt = q.strap_cnt + 2'h1; // [R15]
            end
            // A set in the same cycle as a clear wins
            if (mode_set)
            begin
                d.mode = 1'h1; // [R12] [R13] [R14] [R15] [R21]
                d.halt_exit = !q.mode && halt_mode; // [R10]
            end
            else if (mode_clr)
            begin
                d.mode = 1'h0; // [R16]
            end
        end
        d.fetch_halt = d.mode && !exec_req; // [R8]
        d.wdt_ref = d.mode && wdt_enable; // [R11]
        d.run = !stop_mode; // [R9]
        d.sys_rst = stop_mode && !pin_s; // [R18]
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
            q.st <= S_CAL_WAIT;
            q.oe_n <= 1'h1;
            q.run <= 1'h1;
        end
        else
        begin
            q <= d;
        end
    end

    assign debug_pin_o = q.pin_o;
    assign debug_pin_oe_n = q.oe_n;
    assign tx_ready = q.tx_rdy;
    assign link_abort = q.abort;
    assign frame_err = q.frame_err;
    assign tx_collision = q.collide;
    assign debug_mode = q.mode;
    assign fetch_halt = q.fetch_halt;
    assign halt_exit = q.halt_exit;
    assign wdt_refresh = q.wdt_ref;
    assign periph_run = q.run;
    assign sys_reset_req = q.sys_rst;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_drive_only_tx: assert property ( // [R1]
        !debug_pin_oe_n |-> (q.st == S_TX) || (q.st == S_BRK_TX))
        else $error("pin driven outside transmit");

    a_start_bit_low: assert property ( // [R2]
        (q.st == S_IDLE) && tx_valid && tx_ready |=> !debug_pin_oe_n && (q.cnt == bit_cnt))
        else $error("start bit not driven low");

    a_no_push_uncal: assert property ( // [R3]
        !q.cal |-> !q.push)
        else $error("byte pushed before calibration");

    a_cal_bit_time: assert property ( // [R4]
        (q.st == S_CAL_MEAS) && pin_s && (q.low_run >= CAL_MIN)
        |=> q.cal && (q.bit_t == $past(q.low_run[CAL_SHIFT+BIT_W-1:CAL_SHIFT])))
        else $error("bit time not taken from calibration");

    a_break_detect: assert property ( // [R7]
        listening && !pin_s && (q.low_run >= brk_lim) |=> (q.st == S_BRK_TX) && link_abort)
        else $error("break not detected");

    a_collision: assert property ( // [R25]
        (q.st == S_TX) && debug_pin_oe_n && !pin_s && (q.cnt == half_cnt)
        |=> tx_collision ##1 !debug_pin_oe_n)
        else $error("collision missed");

    a_fetch_halted: assert property ( // [R8]
        $rose(debug_mode) |-> fetch_halt || $past(exec_req))
        else $error("fetch runs in debug mode");

    a_wdt_refresh: assert property ( // [R11]
        debug_mode && $past(wdt_enable) |-> wdt_refresh)
        else $error("watchdog not refreshed");

    a_bp_entry: assert property ( // [R13]
        bp_hit && bp_enable && !dev_rst |=> debug_mode)
        else $error("breakpoint did not enter debug mode");

    a_clear_exit: assert property ( // [R16]
        mode_clr && !mode_set && !dev_rst |=> !debug_mode)
        else $error("mode bit clear did not exit");

    a_stop_reset: assert property ( // [R18]
        stop_mode && !pin_s |=> sys_reset_req)
        else $error("stop mode wake reset missing");

endmodule // debug_link_top

//--- host_model.sv
module host_model
(
    input wire logic sys_clk,
    input wire logic pin,
    output logic pull_low
);
    timeunit 1ns;
    timeprecision 1ps;
    // Clock over eight per bit, the fastest rate worth trusting
    localparam int BT = 8;

    initial pull_low = 1'h0;

    // Open drain: the host only ever pulls low or lets go
    task automatic low_for(input int n);
        @(posedge sys_clk) pull_low <= 1'h1;
        repeat (n) @(posedge sys_clk);
        pull_low <= 1'h0;
    endtask

    task automatic send_byte(input logic [7:0] b, input logic stop_hi);
        @(posedge sys_clk) pull_low <= 1'h1;
        repeat (BT) @(posedge sys_clk);
        for (int i = 0; i < 8; i++)
        begin
            pull_low <= !b[i];
            repeat (BT) @(posedge sys_clk);
        end
        pull_low <= !stop_hi;
        repeat (BT + BT / 2) @(posedge sys_clk);
        pull_low <= 1'h0;
        repeat (BT) @(posedge sys_clk);
    endtask

    task automatic recv_byte(output logic [7:0] b, output logic ok);
        ok = 1'h0;
        b = 8'h00;
        for (int n = 0; n < 400 && !ok; n++)
        begin
            @(posedge sys_clk);
            ok = (pin === 1'h0);
        end
        repeat (BT / 2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BT) @(posedge sys_clk);
            b[i] = pin;
        end
        repeat (BT) @(posedge sys_clk);
    endtask
endmodule // host_model

//--- single_pin_debug_link_autobaud_test.sv
module single_pin_debug_link_autobaud_test
    import link_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk, rst, pull_low, debug_pin_o, debug_pin_oe_n;
    logic [7:0] rx_data, tx_data, hb;
    logic rx_valid, rx_ready, tx_valid, tx_ready, link_abort, frame_err, tx_collision;
    logic ctl_write, ctl_mode_bit, bp_hit, bp_enable, wp_match, exec_req, halt_mode;
    logic stop_mode, wdt_enable, por_reset, brownout_reset, reset_pin_n;
    logic debug_mode, fetch_halt, halt_exit, wdt_refresh, periph_run, sys_reset_req;
    logic seen, hok;
    int n_fail, compares, cycles;
    wire logic pin;
    typedef enum int {P_CTL, P_BP, P_WP, P_POR, P_BOR, P_POP} pulse_t;

    // Pull-up wins unless either side pulls the wire low
    assign pin = (debug_pin_oe_n === 1'h0) ? debug_pin_o : !pull_low;

    host_model host (.sys_clk(sys_clk), .pin(pin), .pull_low(pull_low));

    debug_link_top dut (.sys_clk(sys_clk), .rst(rst), .debug_pin_i(pin),
        .debug_pin_o(debug_pin_o), .debug_pin_oe_n(debug_pin_oe_n), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .link_abort(link_abort), .frame_err(frame_err),
        .tx_collision(tx_collision), .ctl_write(ctl_write), .ctl_mode_bit(ctl_mode_bit),
        .bp_hit(bp_hit), .bp_enable(bp_enable), .wp_match(wp_match), .exec_req(exec_req),
        .halt_mode(halt_mode), .stop_mode(stop_mode), .wdt_enable(wdt_enable),
        .por_reset(por_reset), .brownout_reset(brownout_reset), .reset_pin_n(reset_pin_n),
        .debug_mode(debug_mode), .fetch_halt(fetch_halt), .halt_exit(halt_exit),
        .wdt_refresh(wdt_refresh), .periph_run(periph_run), .sys_reset_req(sys_reset_req));

    initial
    begin
        sys_clk = 1'h0;
        forever #(CLK_PERIOD_NS / 2) sys_clk = !sys_clk;
    end

    task automatic print_verdict();
        if (n_fail == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            n_fail++;
            $display("BAD %0t timeout", $time);
            print_verdict();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_for(ref logic s, input logic v, input int n);
        seen = 1'h0;
        for (int i = 0; i < n && !seen; i++)
        begin
            @(posedge sys_clk);
            #1;
            seen = (s === v);
        end
    endtask

    // Selected by name, since a reference argument cannot take a nonblocking write
    task automatic strobe(input pulse_t k);
        for (int i = 1; i >= 0; i--)
        begin
            @(posedge sys_clk);
            case (k)
                P_CTL: ctl_write <= 1'(i);
                P_BP: bp_hit <= 1'(i);
                P_WP: wp_match <= 1'(i);
                P_POR: por_reset <= 1'(i);
                P_BOR: brownout_reset <= 1'(i);
                default: rx_ready <= 1'(i);
            endcase
        end
    endtask

    task automatic do_reset();
        @(posedge sys_clk) rst <= 1'h1;
        repeat (16) @(posedge sys_clk);
        rst <= 1'h0;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic mode_is(input logic v);
        repeat (3) @(posedge sys_clk);
        #1;
        check(debug_mode, v);
    endtask

    // Waits out any break the device sends, then calibrates at eight clocks a bit
    task automatic recal();
        wait_for(debug_pin_oe_n, 1'h1, 500);
        repeat (8) @(posedge sys_clk);
        host.low_for(8 * CAL_LOW_BITS);
        repeat (16) @(posedge sys_clk);
        check(tx_ready, 1'h1);
        check(rx_valid, 1'h0);
    endtask

    task automatic test_stop();
        @(posedge sys_clk) stop_mode <= 1'h1;
        mode_is(1'h0);
        check(periph_run, 1'h0);
        fork
            host.low_for(10);
            wait_for(sys_reset_req, 1'h1, 12);
        join
        check(seen, 1'h1);
        @(posedge sys_clk) stop_mode <= 1'h0;
        mode_is(1'h0);
        check(periph_run, 1'h1);
    endtask

    task automatic test_mode();
        @(posedge sys_clk) halt_mode <= 1'h1;
        ctl_mode_bit <= 1'h1;
        fork
            strobe(P_CTL);
            wait_for(halt_exit, 1'h1, 5);
        join
        check(seen, 1'h1);
        mode_is(1'h1);
        check(fetch_halt, 1'h1);
        check(wdt_refresh, 1'h1);
        check(periph_run, 1'h1);
        @(posedge sys_clk) exec_req <= 1'h1;
        mode_is(1'h1);
        check(fetch_halt, 1'h0);
        @(posedge sys_clk) exec_req <= 1'h0;
        ctl_mode_bit <= 1'h0;
        strobe(P_CTL);
        mode_is(1'h0);
        check(wdt_refresh, 1'h0);
        strobe(P_BP);
        mode_is(1'h0);
        @(posedge sys_clk) bp_enable <= 1'h1;
        strobe(P_BP);
        mode_is(1'h1);
        strobe(P_POR);
        mode_is(1'h0);
        strobe(P_WP);
        mode_is(1'h1);
        strobe(P_BOR);
        mode_is(1'h0);
        strobe(P_WP);
        @(posedge sys_clk) reset_pin_n <= 1'h0;
        repeat (4) @(posedge sys_clk);
        reset_pin_n <= 1'h1;
        mode_is(1'h0);
    endtask

    // Sixteen bytes fill the buffer, then it drains in arrival order
    task automatic test_fifo();
        for (int i = 0; i < FIFO_DEPTH; i++)
            host.send_byte(8'hA5 + 8'(i * 29), 1'h1);
        for (int i = 0; i < FIFO_DEPTH; i++)
        begin
            #1;
            check(rx_valid, 1'h1);
            check(rx_data, 8'hA5 + 8'(i * 29));
            strobe(P_POP);
            @(posedge sys_clk);
        end
        #1;
        check(rx_valid, 1'h0);
    endtask

    task automatic send_tx(input logic [7:0] b);
        @(posedge sys_clk) tx_data <= b;
        tx_valid <= 1'h1;
        for (int i = 0; i < 100; i++)
        begin
            @(posedge sys_clk);
            if (tx_ready === 1'h1)
                break;
        end
        tx_valid <= 1'h0;
    endtask

    task automatic test_tx();
        for (int i = 0; i < 2; i++)
        begin
            fork
                send_tx(8'h3C ^ 8'(i * 255));
                host.recv_byte(hb, hok);
            join
            check(hok, 1'h1);
            check(hb, 8'h3C ^ 8'(i * 255));
            check(debug_pin_o, 1'h0);
        end
    endtask

    task automatic test_errors();
        strobe(P_CTL);
        fork
            host.low_for(9 * 8 + 8);
            wait_for(link_abort, 1'h1, 90);
        join
        check(seen, 1'h1);
        #1;
        check(debug_pin_oe_n, 1'h0);
        wait_for(debug_pin_oe_n, 1'h1, 400);
        repeat (4) @(posedge sys_clk);
        check(tx_ready, 1'h0);
        mode_is(1'h1);
        recal();
        fork
            host.send_byte(8'hFF, 1'h0);
            wait_for(frame_err, 1'h1, 120);
        join
        check(seen, 1'h1);
        recal();
        fork
            send_tx(8'hFF);
            begin
                // Not wait_for: its flag would end the collision watch early
                @(negedge debug_pin_oe_n);
                repeat (10) @(posedge sys_clk);
                host.low_for(8);
            end
            wait_for(tx_collision, 1'h1, 60);
        join
        check(seen, 1'h1);
        recal();
    endtask

    initial
    begin
        rst = 1'h1;
        {rx_ready, tx_valid, ctl_write, ctl_mode_bit, bp_hit, bp_enable} = '0;
        {wp_match, exec_req, halt_mode, stop_mode, por_reset, brownout_reset} = '0;
        tx_data = 8'h00;
        wdt_enable = 1'h1;
        reset_pin_n = 1'h1;
        n_fail = 0;
        compares = 0;
        cycles = 0;
        do_reset();
        check(debug_pin_oe_n, 1'h1);
        check(tx_ready, 1'h0);
        check(debug_mode, 1'h0);
        test_stop();
        test_mode();
        recal();
        test_fifo();
        test_tx();
        ctl_mode_bit <= 1'h1;
        test_errors();
        fork
            host.low_for(40);
            do_reset();
        join
        mode_is(1'h1);
        print_verdict();
    end
endmodule // single_pin_debug_link_autobaud_test
